/* File: hw/hde_top.sv */
// distortion event block: pick-up, blocking, timers, events, counters, log
// Notes on behaviour
// - status shows normal, start, alarm or blocked
// - block sampled at start of each cycle
// - block comes from dedicated routed input
// - unblocked pick-up raises start, starts timer
// - blocked pick-up gives blocked, no timing
// - block during start drops start like release
// - only fixed definite delay characteristic
// - per channel delay, 5 ms steps, up to 1800 s
// - on and off events per source
// - per event on/off write selection
// - every event carries a time stamp
// - clearable start, alarm, blocked counters
// - twelve-entry circular log on on edges
// - record: time, identity, phase values, group
// - start, alarm, blocked as binary outputs
// - pick-up when distortion exceeds setting
// - release below 97 percent of setting
// - disabled channel never picks up
// - common amplitude or power ratio select
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "hde_cfg.svh"
module hde_top #(
  parameter int unsigned CYCLE_CLKS = `HDE_CYCLE_CLKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measured distortion, 0.01 percent units
  input wire hde_pkg::hde_thd_t amp_l1,
  input wire hde_pkg::hde_thd_t amp_l2,
  input wire hde_pkg::hde_thd_t amp_l3,
  input wire hde_pkg::hde_thd_t amp_res1,
  input wire hde_pkg::hde_thd_t amp_res2,
  input wire hde_pkg::hde_thd_t pow_l1,
  input wire hde_pkg::hde_thd_t pow_l2,
  input wire hde_pkg::hde_thd_t pow_l3,
  input wire hde_pkg::hde_thd_t pow_res1,
  input wire hde_pkg::hde_thd_t pow_res2,
  // system inputs
  input wire logic block_in,
  input wire logic [47:0] time_ms,
  input wire logic [2:0] setting_group,
  // binary outputs
  output logic [2:0] start_out,
  output logic [2:0] alarm_out,
  output logic blocked_out,
  // event strobes: bits 2:0 start, 5:3 alarm, 6 blocked
  output logic [6:0] evt_on,
  output logic [6:0] evt_off,
  output logic [47:0] evt_stamp
);
  logic [16:0] cyc_q;
  logic tick_q;
  logic eval_q;
  logic blk_s_q;
  logic [2:0] pick_q;
  logic [4:0] ctrl_q;
  hde_pkg::hde_thd_t pu_q [3];
  hde_pkg::hde_dly_t dly_q [3];
  logic [31:0] evt_cfg_q;
  logic [31:0] cnt_q [3];
  logic [3:0] log_sel_q;
  logic [3:0] wptr_q;
  logic [3:0] lcnt_q;
  logic blocked_q;
  logic [6:0] src_prev_q;
  logic [6:0] evt_on_q;
  logic [6:0] evt_off_q;
  logic [47:0] evt_stamp_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic [2:0] ch_start;
  logic [2:0] ch_alarm;
  logic [2:0] ch_blocked;
  hde_pkg::hde_state_t ch_state [3];
  logic [6:0] src;
  logic [6:0] rise;
  logic [6:0] fall;
  logic wr_en;
  logic [2:0] clr;
  hde_pkg::hde_thd_t v_l1, v_l2, v_l3, v_r1, v_r2;
  logic [`HDE_REC_W-1:0] rec;
  logic [`HDE_REC_W-1:0] log_rd;

  function automatic hde_pkg::hde_thd_t sel_ratio(input logic pwr, input hde_pkg::hde_thd_t a,
                                                   input hde_pkg::hde_thd_t p);
    sel_ratio = pwr ? p : a;
  endfunction

  function automatic logic under_reset(input hde_pkg::hde_thd_t v, input hde_pkg::hde_thd_t s);
    under_reset = (23'(v) * `HDE_PCT_FULL) < (23'(s) * `HDE_PCT_RESET);
  endfunction

  function automatic logic pick_next(input logic prev, input logic en, input logic above,
                                     input logic below);
    if (!en)
      pick_next = 1'b0;
    else if (!prev)
      pick_next = above;
    else
      pick_next = !below;
  endfunction

  function automatic logic [1:0] state_code(input hde_pkg::hde_state_t s);
    unique case (s)
      hde_pkg::HDE_ST_NORMAL: state_code = 2'h0;
      hde_pkg::HDE_ST_START: state_code = 2'h1;
      hde_pkg::HDE_ST_ALARM: state_code = 2'h2;
      hde_pkg::HDE_ST_BLOCKED: state_code = 2'h3;
    endcase
  endfunction

  function automatic hde_pkg::hde_dly_t clip_dly(input logic [31:0] w);
    clip_dly = (w > 32'(`HDE_DLY_MAX)) ? `HDE_DLY_MAX : w[18:0];
  endfunction

  // ratio selection common to all channels
  assign v_l1 = sel_ratio(ctrl_q[`HDE_CTRL_PWR_BIT], amp_l1, pow_l1);
  assign v_l2 = sel_ratio(ctrl_q[`HDE_CTRL_PWR_BIT], amp_l2, pow_l2);
  assign v_l3 = sel_ratio(ctrl_q[`HDE_CTRL_PWR_BIT], amp_l3, pow_l3);
  assign v_r1 = sel_ratio(ctrl_q[`HDE_CTRL_PWR_BIT], amp_res1, pow_res1);
  assign v_r2 = sel_ratio(ctrl_q[`HDE_CTRL_PWR_BIT], amp_res2, pow_res2);

  // processing cycle tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_q <= '0;
      tick_q <= 1'b0;
      eval_q <= 1'b0;
    end
    else
    begin
      tick_q <= (cyc_q == 17'(CYCLE_CLKS - 1));
      cyc_q <= (cyc_q == 17'(CYCLE_CLKS - 1)) ? '0 : cyc_q + 17'h00001;
      eval_q <= tick_q;
    end
  end

  // block sample and pick-up with hysteresis, one cycle ahead of evaluation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_s_q <= 1'b0;
      pick_q <= '0;
    end
    else if (tick_q)
    begin
      blk_s_q <= block_in;
      pick_q[0] <= pick_next(pick_q[0], ctrl_q[0],
                             v_l1 > pu_q[0] || v_l2 > pu_q[0] || v_l3 > pu_q[0],
                             under_reset(v_l1, pu_q[0]) && under_reset(v_l2, pu_q[0]) &&
                             under_reset(v_l3, pu_q[0]));
      pick_q[1] <= pick_next(pick_q[1], ctrl_q[1], v_r1 > pu_q[1], under_reset(v_r1, pu_q[1]));
      pick_q[2] <= pick_next(pick_q[2], ctrl_q[2], v_r2 > pu_q[2], under_reset(v_r2, pu_q[2]));
    end
  end

  // channels: phase, residual one, residual two
  for (genvar i = 0; i < 3; i++)
  begin : g_chan
    hde_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .eval_i(eval_q),
      .pick_i(pick_q[i]),
      .blk_i(blk_s_q),
      .en_i(ctrl_q[i]),
      .delay_i(dly_q[i]),
      .state_q(ch_state[i]),
      .start_q(ch_start[i]),
      .alarm_q(ch_alarm[i]),
      .blocked_q(ch_blocked[i])
    );
  end

  assign start_out = ch_start;
  assign alarm_out = ch_alarm;
  assign blocked_out = blocked_q;
  assign src = {blocked_q, ch_alarm, ch_start};
  assign rise = src & ~src_prev_q;
  assign fall = ~src & src_prev_q;

  // events with time stamps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blocked_q <= 1'b0;
      src_prev_q <= '0;
      evt_on_q <= '0;
      evt_off_q <= '0;
      evt_stamp_q <= '0;
    end
    else
    begin
      blocked_q <= |ch_blocked;
      src_prev_q <= src;
      evt_on_q <= rise & evt_cfg_q[6:0];
      evt_off_q <= fall & evt_cfg_q[`HDE_EVT_OFF_LSB+6:`HDE_EVT_OFF_LSB];
      if (|(rise | fall))
      begin
        evt_stamp_q <= time_ms;
      end
    end
  end

  assign evt_on = evt_on_q;
  assign evt_off = evt_off_q;
  assign evt_stamp = evt_stamp_q;

  // fault log
  assign rec = {v_l3, v_l2, v_l1, setting_group, rise, time_ms};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_q <= '0;
      lcnt_q <= '0;
    end
    else if (|rise)
    begin
      wptr_q <= (wptr_q == `HDE_LOG_LAST) ? 4'h0 : wptr_q + 4'h1;
      lcnt_q <= (lcnt_q == `HDE_LOG_DEPTH) ? lcnt_q : lcnt_q + 4'h1;
    end
  end

  hde_log_mem u_log (
    .pclk(pclk),
    .presetn(presetn),
    .we(|rise),
    .waddr(wptr_q),
    .wdata(rec),
    .raddr(log_sel_q),
    .rdata_q(log_rd)
  );

  // apb slave
  assign wr_en = psel && penable && pready_q && pwrite;
  assign clr = (wr_en && paddr == `HDE_OFS_CNT_CLR) ? pwdata[2:0] : 3'h0;

  always_comb
  begin
    rd_d = 32'h00000000;
    unique case (paddr)
      `HDE_OFS_CTRL: rd_d = {27'h0000000, ctrl_q};
      `HDE_OFS_PU_PH: rd_d = {16'h0000, pu_q[0]};
      `HDE_OFS_PU_R1: rd_d = {16'h0000, pu_q[1]};
      `HDE_OFS_PU_R2: rd_d = {16'h0000, pu_q[2]};
      `HDE_OFS_DLY_PH: rd_d = {13'h0000, dly_q[0]};
      `HDE_OFS_DLY_R1: rd_d = {13'h0000, dly_q[1]};
      `HDE_OFS_DLY_R2: rd_d = {13'h0000, dly_q[2]};
      `HDE_OFS_EVT_CFG: rd_d = evt_cfg_q;
      `HDE_OFS_STATUS: rd_d = {15'h0000, blk_s_q, 1'b0, blocked_q, ch_alarm, ch_start,
                                2'h0, state_code(ch_state[2]), state_code(ch_state[1]),
                                state_code(ch_state[0])};
      `HDE_OFS_CNT_START: rd_d = cnt_q[0];
      `HDE_OFS_CNT_ALARM: rd_d = cnt_q[1];
      `HDE_OFS_CNT_BLOCK: rd_d = cnt_q[2];
      `HDE_OFS_LOG_SEL: rd_d = {20'h00000, lcnt_q, wptr_q, log_sel_q};
      `HDE_OFS_LOG_W0: rd_d = log_rd[31:0];
      `HDE_OFS_LOG_W1: rd_d = {6'h00, log_rd[57:32]};
      `HDE_OFS_LOG_W2: rd_d = log_rd[89:58];
      `HDE_OFS_LOG_W3: rd_d = {16'h0000, log_rd[105:90]};
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && !penable;
      prdata_q <= (psel && !penable && !pwrite) ? rd_d : prdata_q;
      pslverr_q <= psel && !penable && (paddr > `HDE_OFS_LOG_W3 || paddr[1:0] != 2'h0);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // settings registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `HDE_CTRL_RST;
      evt_cfg_q <= `HDE_EVT_CFG_RST;
      log_sel_q <= '0;
      for (int i = 0; i < 3; i++)
      begin
        pu_q[i] <= `HDE_PU_DEF;
        dly_q[i] <= `HDE_DLY_DEF;
      end
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `HDE_OFS_CTRL: ctrl_q <= {pwdata[4], 1'b0, pwdata[2:0]};
        `HDE_OFS_PU_PH: pu_q[0] <= pwdata[15:0];
        `HDE_OFS_PU_R1: pu_q[1] <= pwdata[15:0];
        `HDE_OFS_PU_R2: pu_q[2] <= pwdata[15:0];
        `HDE_OFS_DLY_PH: dly_q[0] <= clip_dly(pwdata);
        `HDE_OFS_DLY_R1: dly_q[1] <= clip_dly(pwdata);
        `HDE_OFS_DLY_R2: dly_q[2] <= clip_dly(pwdata);
        `HDE_OFS_EVT_CFG: evt_cfg_q <= pwdata & `HDE_EVT_CFG_RST;
        `HDE_OFS_LOG_SEL: log_sel_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // cumulative counters, a count in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cnt_q[i] <= '0;
      end
    end
    else
    begin
      cnt_q[0] <= (clr[0] ? 32'h0 : cnt_q[0]) + {31'h0, |rise[2:0]};
      cnt_q[1] <= (clr[1] ? 32'h0 : cnt_q[1]) + {31'h0, |rise[5:3]};
      cnt_q[2] <= (clr[2] ? 32'h0 : cnt_q[2]) + {31'h0, rise[6]};
    end
  end

  chk_blk_sample: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> blk_s_q == $past(block_in) && eval_q)
    else $error("block not sampled before evaluation");
  chk_evt_stamp: assert property (@(posedge pclk) disable iff (!presetn)
    |(rise | fall) |=> evt_stamp_q == $past(time_ms))
    else $error("event stamp not captured");
  chk_evt_on: assert property (@(posedge pclk) disable iff (!presetn)
    rise[6] && evt_cfg_q[6] |=> evt_on_q[6] && !evt_off_q[6])
    else $error("blocked on event missing");
  chk_log_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    |rise && wptr_q == `HDE_LOG_LAST |=> wptr_q == 4'h0 && lcnt_q != 4'h0)
    else $error("log pointer did not wrap");
  chk_cnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clr[1] && !(|rise[5:3]) |=> cnt_q[1] == 32'h0)
    else $error("alarm counter not cleared");
  chk_blocked_out: assert property (@(posedge pclk) disable iff (!presetn)
    |ch_blocked |=> blocked_out)
    else $error("blocked output missing");
endmodule

/* File: hw/hde_cfg.svh */
// constants for the distortion event block: offsets, fields, resets, timing
`ifndef HDE_CFG_SVH
`define HDE_CFG_SVH
// timing
`define HDE_CLK_NS 40
`define HDE_CYCLE_US 5000
`define HDE_CYCLE_CLKS ((`HDE_CYCLE_US * 1000) / `HDE_CLK_NS)
`define HDE_BLK_LEAD_US 5000
`define HDE_DLY_STEP_US 5000
`define HDE_DLY_MAX 19'h57E40
`define HDE_DLY_DEF 19'h007D0
`define HDE_PU_DEF 16'h03E8
`define HDE_PCT_FULL 23'h000064
`define HDE_PCT_RESET 23'h000061
// log
`define HDE_LOG_DEPTH 4'hC
`define HDE_LOG_LAST 4'hB
`define HDE_REC_W 106
`define HDE_REC_ID_LSB 48
`define HDE_REC_GRP_LSB 55
`define HDE_REC_L1_LSB 58
`define HDE_REC_L2_LSB 74
`define HDE_REC_L3_LSB 90
// register offsets
`define HDE_OFS_CTRL 8'h00
`define HDE_OFS_PU_PH 8'h04
`define HDE_OFS_PU_R1 8'h08
`define HDE_OFS_PU_R2 8'h0C
`define HDE_OFS_DLY_PH 8'h10
`define HDE_OFS_DLY_R1 8'h14
`define HDE_OFS_DLY_R2 8'h18
`define HDE_OFS_EVT_CFG 8'h1C
`define HDE_OFS_STATUS 8'h20
`define HDE_OFS_CNT_START 8'h24
`define HDE_OFS_CNT_ALARM 8'h28
`define HDE_OFS_CNT_BLOCK 8'h2C
`define HDE_OFS_CNT_CLR 8'h30
`define HDE_OFS_LOG_SEL 8'h34
`define HDE_OFS_LOG_W0 8'h38
`define HDE_OFS_LOG_W1 8'h3C
`define HDE_OFS_LOG_W2 8'h40
`define HDE_OFS_LOG_W3 8'h44
// fields and reset values
`define HDE_CTRL_PWR_BIT 4
`define HDE_CTRL_RST 5'h07
`define HDE_EVT_OFF_LSB 16
`define HDE_EVT_CFG_RST 32'h007F007F
`endif

/* File: hw/hde_pkg.sv */
// types of the distortion event block
package hde_pkg;
  typedef enum logic [3:0] {
    HDE_ST_NORMAL = 4'h1,
    HDE_ST_START = 4'h2,
    HDE_ST_ALARM = 4'h4,
    HDE_ST_BLOCKED = 4'h8
  } hde_state_t;
  typedef logic [15:0] hde_thd_t;
  typedef logic [18:0] hde_dly_t;
endpackage

/* File: hw/hde_log_mem.sv */
// twelve-slot record memory with registered read data
`timescale 1ns/1ns
`include "hde_cfg.svh"
module hde_log_mem (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [`HDE_REC_W-1:0] wdata,
  // read port
  input wire logic [3:0] raddr,
  output logic [`HDE_REC_W-1:0] rdata_q
);
  logic [`HDE_REC_W-1:0] mem [12];

  always_ff @(posedge pclk)
  begin
    if (we && waddr < `HDE_LOG_DEPTH)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= '0;
    end
    else if (raddr < `HDE_LOG_DEPTH)
    begin
      rdata_q <= mem[raddr];
    end
    else
    begin
      rdata_q <= '0;
    end
  end
endmodule

/* File: hw/hde_chan.sv */
// one supervised channel: start, blocked and definite-time alarm
`timescale 1ns/1ns
`include "hde_cfg.svh"
module hde_chan (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // cycle evaluation inputs
  input wire logic eval_i,
  input wire logic pick_i,
  input wire logic blk_i,
  input wire logic en_i,
  input wire hde_pkg::hde_dly_t delay_i,
  // outputs
  output hde_pkg::hde_state_t state_q,
  output logic start_q,
  output logic alarm_q,
  output logic blocked_q
);
  hde_pkg::hde_state_t st_d;
  hde_pkg::hde_dly_t cnt_q;
  hde_pkg::hde_dly_t cnt_d;
  hde_pkg::hde_dly_t cnt_inc;

  assign cnt_inc = cnt_q + 19'h00001;

  always_comb
  begin
    st_d = state_q;
    cnt_d = cnt_q;
    if (eval_i)
    begin
      cnt_d = '0;
      if (!en_i || !pick_i)
      begin
        st_d = hde_pkg::HDE_ST_NORMAL;
      end
      else if (blk_i)
      begin
        st_d = hde_pkg::HDE_ST_BLOCKED;
      end
      else
      begin
        unique case (state_q)
          hde_pkg::HDE_ST_START:
          begin
            cnt_d = cnt_inc;
            st_d = (cnt_inc >= delay_i) ? hde_pkg::HDE_ST_ALARM : hde_pkg::HDE_ST_START;
          end
          hde_pkg::HDE_ST_ALARM:
          begin
            st_d = hde_pkg::HDE_ST_ALARM;
          end
          hde_pkg::HDE_ST_NORMAL, hde_pkg::HDE_ST_BLOCKED:
          begin
            st_d = (delay_i == '0) ? hde_pkg::HDE_ST_ALARM : hde_pkg::HDE_ST_START;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= hde_pkg::HDE_ST_NORMAL;
      cnt_q <= '0;
      start_q <= 1'b0;
      alarm_q <= 1'b0;
      blocked_q <= 1'b0;
    end
    else
    begin
      state_q <= st_d;
      cnt_q <= cnt_d;
      start_q <= (st_d == hde_pkg::HDE_ST_START) || (st_d == hde_pkg::HDE_ST_ALARM);
      alarm_q <= (st_d == hde_pkg::HDE_ST_ALARM);
      blocked_q <= (st_d == hde_pkg::HDE_ST_BLOCKED);
    end
  end

  chk_start_go: assert property (@(posedge pclk) disable iff (!presetn)
    eval_i && en_i && pick_i && !blk_i |=> start_q && !blocked_q)
    else $error("start not raised on unblocked pick-up");
  chk_start_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    eval_i && en_i && pick_i && blk_i |=> blocked_q && !start_q && !alarm_q)
    else $error("blocked pick-up did not give blocked only");
  chk_block_release: assert property (@(posedge pclk) disable iff (!presetn)
    start_q && eval_i && blk_i |=> !start_q && !alarm_q && cnt_q == '0)
    else $error("start kept or timer kept after block");
  chk_chan_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    eval_i && !en_i |=> !start_q && !alarm_q && !blocked_q)
    else $error("disabled channel still active");
  chk_alarm_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(alarm_q) |-> $past(state_q) != hde_pkg::HDE_ST_START || $past(cnt_inc) >= delay_i)
    else $error("alarm before delay expired");
  chk_alarm_start: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_q |-> start_q && state_q == hde_pkg::HDE_ST_ALARM)
    else $error("alarm without start");
endmodule

/* File: tb/hde_far_side.sv */
// far side model: routed block source, time source and event buffer
`timescale 1ns/1ns
module hde_far_side (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic block_req,
  input wire logic clr,
  // towards the block
  output logic block_in,
  output logic [47:0] time_ms,
  // events from the block
  input wire logic [6:0] evt_on,
  input wire logic [6:0] evt_off,
  input wire logic [47:0] evt_stamp,
  // buffer view
  output logic [6:0] seen_on,
  output logic [6:0] seen_off,
  output logic [47:0] first_stamp
);
  // routed block source, changed only at clock edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      block_in <= 1'b0;
    else
      block_in <= block_req;
  end
  // running time stamp
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      time_ms <= 48'h1;
    else
      time_ms <= time_ms + 48'h1;
  end
  // event buffer: collect on/off strobes and the first on stamp
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen_on <= 7'h00;
      seen_off <= 7'h00;
      first_stamp <= 48'h0;
    end
    else if (clr)
    begin
      seen_on <= 7'h00;
      seen_off <= 7'h00;
      first_stamp <= 48'h0;
    end
    else
    begin
      seen_on <= seen_on | evt_on;
      seen_off <= seen_off | evt_off;
      if (evt_on != 7'h00 && seen_on == 7'h00)
        first_stamp <= evt_stamp;
    end
  end
endmodule

/* File: tb/hde_top_tb_top.sv */
// testbench for the distortion event block
`timescale 1ns/1ns
`include "hde_cfg.svh"
module hde_top_tb_top;
  localparam int CYC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, block_in, blocked_out, blk = 1'b0, clr = 1'b0;
  hde_pkg::hde_thd_t amp_l1 = 16'h0, amp_l2 = 16'h0, amp_res1 = 16'h0, amp_res2 = 16'h0;
  hde_pkg::hde_thd_t pow_l1 = 16'h0, pow_l2 = 16'h0, pow_l3 = 16'h0, pow_res1 = 16'h0;
  hde_pkg::hde_thd_t amp_l3 = 16'h0, pow_res2 = 16'h0;
  logic [47:0] time_ms, evt_stamp, first_stamp;
  logic [2:0] setting_group = 3'h0;
  logic [2:0] start_out, alarm_out;
  logic [6:0] evt_on, evt_off, seen_on, seen_off;
  logic [6:0] outs;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  assign outs = {blocked_out, alarm_out, start_out};
  always #20 pclk = ~pclk;
  hde_top #(.CYCLE_CLKS(CYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .amp_l1(amp_l1), .amp_l2(amp_l2), .amp_l3(amp_l3),
    .amp_res1(amp_res1), .amp_res2(amp_res2), .pow_l1(pow_l1), .pow_l2(pow_l2),
    .pow_l3(pow_l3), .pow_res1(pow_res1), .pow_res2(pow_res2), .block_in(block_in),
    .time_ms(time_ms), .setting_group(setting_group), .start_out(start_out),
    .alarm_out(alarm_out), .blocked_out(blocked_out), .evt_on(evt_on), .evt_off(evt_off),
    .evt_stamp(evt_stamp));
  hde_far_side far (.pclk(pclk), .presetn(presetn), .block_req(blk), .clr(clr),
    .block_in(block_in), .time_ms(time_ms), .evt_on(evt_on), .evt_off(evt_off),
    .evt_stamp(evt_stamp), .seen_on(seen_on), .seen_off(seen_off),
    .first_stamp(first_stamp));
  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    r = 32'h0;
    e = 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, pready);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask
  task automatic wait_out(input int i, input logic v);
    int n;
    for (n = 0; n < 200; n++)
    begin
      if (outs[i] === v)
        break;
      @(posedge pclk);
    end
  endtask
  task automatic clr_evt;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    chk("outs after reset", 0, outs);
    rd("ctrl", `HDE_OFS_CTRL, 32'h7);
    rd("pickup", `HDE_OFS_PU_PH, 32'h3E8);
    rd("delay", `HDE_OFS_DLY_R2, 32'h7D0);
    rd("evt cfg", `HDE_OFS_EVT_CFG, 32'h007F007F);
    wr(`HDE_OFS_DLY_R1, 32'hFFFFF);
    rd("delay clip", `HDE_OFS_DLY_R1, 32'h57E40);
    apb(1'b0, 8'h48, 32'h0, r, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
  endtask
  task automatic t_alarm;
    int m;
    logic [31:0] r;
    logic e;
    wr(`HDE_OFS_DLY_PH, 32'h3);
    clr_evt();
    setting_group <= 3'h3;
    amp_l2 <= 16'h03E9;
    wait_out(0, 1'b1);
    chk("start ph", 1, outs[0]);
    for (m = 0; m < 200 && outs[3] !== 1'b1; m++)
      @(posedge pclk);
    chk("alarm delay", 3 * CYC, m);
    repeat (2) @(posedge pclk);
    chk("on events", 7'h09, seen_on);
    apb(1'b0, `HDE_OFS_STATUS, 32'h0, r, e);
    chk("status", 32'h0902, r & 32'h4903);
    amp_l2 <= 16'h03D4;
    repeat (3 * CYC) @(posedge pclk);
    chk("hysteresis", 3'h1, {outs[0], outs[3], outs[6]} & 3'h4 ? 3'h1 : 3'h0);
    amp_l2 <= 16'h03C9;
    wait_out(0, 1'b0);
    chk("release", 2'b00, {outs[0], outs[3]});
    repeat (2) @(posedge pclk);
    chk("off events", 7'h09, seen_off);
    rd("start count", `HDE_OFS_CNT_START, 32'h1);
    rd("alarm count", `HDE_OFS_CNT_ALARM, 32'h1);
    wr(`HDE_OFS_LOG_SEL, 32'h0);
    apb(1'b0, `HDE_OFS_LOG_W1, 32'h0, r, e);
    chk("log id group", 10'h181, r[25:16]);
    rd("log time", `HDE_OFS_LOG_W0, first_stamp[31:0]);
    wr(`HDE_OFS_CNT_CLR, 32'h7);
    rd("start count clr", `HDE_OFS_CNT_START, 32'h0);
    amp_l2 <= 16'h0;
  endtask
  task automatic t_block;
    clr_evt();
    blk <= 1'b1;
    repeat (2 * CYC) @(posedge pclk);
    amp_res2 <= 16'h07D0;
    wait_out(6, 1'b1);
    chk("blocked", 2'b10, {outs[6], outs[2]});
    repeat (2) @(posedge pclk);
    chk("blocked on", 7'h40, seen_on);
    blk <= 1'b0;
    wait_out(2, 1'b1);
    chk("start after block", 1, outs[2]);
    clr_evt();
    blk <= 1'b1;
    wait_out(2, 1'b0);
    chk("start dropped", 2'b00, {outs[2], outs[5]});
    repeat (2) @(posedge pclk);
    chk("start off evt", 1, seen_off[2]);
    amp_res2 <= 16'h0;
    repeat (2 * CYC) @(posedge pclk);
    blk <= 1'b0;
    wait_out(6, 1'b0);
  endtask
  task automatic t_modes;
    wr(`HDE_OFS_CTRL, 32'h6);
    amp_l1 <= 16'h1388;
    repeat (3 * CYC) @(posedge pclk);
    chk("disabled", 0, outs[0]);
    amp_l1 <= 16'h0;
    wr(`HDE_OFS_CTRL, 32'h17);
    wr(`HDE_OFS_EVT_CFG, 32'h007D007F);
    clr_evt();
    amp_res1 <= 16'h0100;
    pow_res1 <= 16'h07D0;
    wait_out(1, 1'b1);
    chk("power start", 1, outs[1]);
    pow_res1 <= 16'h0;
    wait_out(1, 1'b0);
    chk("power release", 0, outs[1]);
    repeat (2) @(posedge pclk);
    chk("on selected", 1, seen_on[1]);
    chk("off masked", 0, seen_off[1]);
  endtask
  task automatic t_wrap;
    int k;
    wr(`HDE_OFS_DLY_PH, 32'h0);
    for (k = 0; k < 6; k++)
    begin
      pow_l3 <= 16'h07D0;
      wait_out(3, 1'b1);
      chk("zero delay", 1, outs[0]);
      pow_l3 <= 16'h0;
      wait_out(3, 1'b0);
    end
    rd("log fill", `HDE_OFS_LOG_SEL, 32'h00000C00);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_alarm();
    t_block();
    t_modes();
    t_wrap();
    tally_and_finish();
  end
endmodule
